// ---- rtl/dacx_aux_regs.sv ----
// Auxiliary control bank: crossing, analog trims, self-test and controller clock divider
`timescale 1ns/1ns
// Notes on behaviour
// - Six-bit upward crossing shift, reset zero; software keeps it zero when downward nonzero.
// - Six-bit downward crossing shift, reset zero; software keeps it zero when upward nonzero.
// - Mirror roll-off: 00 bypass, 01 narrow, 10 medium, 11 wide.
// - Three-bit bandgap trim in low bits of first analog register, reset 000.
// - Headroom byte: upper nibble reference offset, lower nibble overdrive; recommended 0xCA.
// - Result selector picks LVDS phase 1/2 or SYNC phase 1/2 signature.
// - Writing one to readback bit enables signature readback; zero does nothing.
// - Writing one to LVDS enable starts LVDS capture self-test; zero does nothing.
// - Writing one to SYNC enable starts domain-transfer self-test; zero does nothing.
// - Writing one to clear resets all self-test result registers; zero does nothing.
// - 32-bit result read as bytes, LSB at 0x12 through MSB at 0x15.
// - Controller clock equals sample clock over two to the power code plus four.
// - A written byte takes effect right after its last bit shifts in if clk_en is high; with clk_en low it is ignored.
module dacx_aux_regs
    import dacx_pkg::*;
#(
    parameter int DIV_CODE_W = 4
)
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire dacx_pkg::dacx_wr_t wr,
    input wire logic [4:0] rd_addr,
    output logic [7:0] rd_data,
    output logic rd_hit,
    input wire dacx_pkg::dacx_sig_t sig_in,
    input wire logic sig_valid,
    output dacx_pkg::dacx_trim_t trim,
    output logic lvds_selftest_en,
    output logic sync_selftest_en,
    output logic selftest_clear,
    output logic signature_readback_enable,
    output logic ctrl_clk
);
    import dacx_pkg::*;

    localparam int DIV_CNT_W = (1 << DIV_CODE_W) + DIV_BASE_SHIFT;
    // Tap index wide enough that the top code does not wrap to a low bit
    localparam int TAP_W = $clog2(DIV_CNT_W);

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [5:0] up_q, up_d;
    logic [5:0] dn_q, dn_d;
    dacx_mirror_t mir_q, mir_d;
    logic [2:0] bg_q, bg_d;
    logic [7:0] output_headroom_q, output_headroom_d;
    dacx_sig_sel_t sel_q, sel_d;
    logic rdbk_q, rdbk_d;
    logic lvds_q, lvds_d;
    logic sync_q, sync_d;
    logic clr_q, clr_d;
    logic [31:0] res_q, res_d;
    logic [3:0] ccd_q, ccd_d;
    logic [DIV_CNT_W-1:0] div_q, div_d;
    logic cclk_q, cclk_d;

    logic wr_cross_up, wr_cross_dn, wr_ana1, wr_ana2, wr_st, wr_div;
    logic [31:0] sig_mux;

    // ----------------------------------------------------------------
    // Write decode
    // ----------------------------------------------------------------
    // Byte strobe arrives at the last shifted bit, so fields update the next edge
    always_comb
    begin
        wr_cross_up = wr.wr_stb && wr.addr == ADDR_CROSS_UP;
        wr_cross_dn = wr.wr_stb && wr.addr == ADDR_CROSS_DOWN;
        wr_ana1 = wr.wr_stb && wr.addr == ADDR_ANA_MIRROR_BG;
        wr_ana2 = wr.wr_stb && wr.addr == ADDR_HEADROOM;
        wr_st = wr.wr_stb && wr.addr == ADDR_SELF_TEST_CTRL;
        wr_div = wr.wr_stb && wr.addr == ADDR_CLK_DIV;
    end

    always_comb
    begin
        unique case (sel_q)
            DACX_SIG_LVDS_P1: sig_mux = sig_in.lvds_p1;
            DACX_SIG_LVDS_P2: sig_mux = sig_in.lvds_p2;
            DACX_SIG_SYNC_P1: sig_mux = sig_in.sync_p1;
            DACX_SIG_SYNC_P2: sig_mux = sig_in.sync_p2;
        endcase
    end

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb
    begin
        up_d = up_q;
        dn_d = dn_q;
        mir_d = mir_q;
        bg_d = bg_q;
        output_headroom_d = output_headroom_q;
        sel_d = sel_q;
        rdbk_d = rdbk_q;
        lvds_d = lvds_q;
        sync_d = sync_q;
        clr_d = 1'b0;
        res_d = res_q;
        ccd_d = ccd_q;
        // Both shift fields stored as written; exclusivity is software's job
        if (wr_cross_up)
        begin
            up_d = wr.wdata[CROSS_LSB +: CROSS_W];
        end
        if (wr_cross_dn)
        begin
            dn_d = wr.wdata[CROSS_LSB +: CROSS_W];
        end
        if (wr_ana1)
        begin
            mir_d = dacx_mirror_t'(wr.wdata[MIRROR_LSB +: 2]);
            bg_d = wr.wdata[BANDGAP_LSB +: 3];
        end
        if (wr_ana2)
        begin
            output_headroom_d = wr.wdata;
        end
        if (wr_st)
        begin
            sel_d = dacx_sig_sel_t'(wr.wdata[ST_SEL_LSB +: 2]);
            // Enable bits are set-only: a written zero leaves them as they are
            if (wr.wdata[ST_READBACK_BIT])
            begin
                rdbk_d = 1'b1;
            end
            if (wr.wdata[ST_LVDS_EN_BIT])
            begin
                lvds_d = 1'b1;
            end
            if (wr.wdata[ST_SYNC_EN_BIT])
            begin
                sync_d = 1'b1;
            end
        end
        if (wr_div)
        begin
            ccd_d = wr.wdata[DIV_CODE_LSB +: 4];
        end
        // Result captured only while readback is on and a checker reports valid
        if (rdbk_q && sig_valid)
        begin
            res_d = sig_mux;
        end
        if (wr_st && wr.wdata[ST_CLEAR_BIT])
        begin
            // Clear also drops the run enables so a fresh run must be requested
            res_d = 32'h0000_0000;
            clr_d = 1'b1;
            lvds_d = 1'b0;
            sync_d = 1'b0;
            rdbk_d = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Controller clock divider
    // ----------------------------------------------------------------
    always_comb
    begin
        div_d = div_q + DIV_CNT_W'(1);
        // Tap bit (code+3) toggles at sample clock / 2^(code+4)
        cclk_d = div_q[TAP_W'(ccd_q) + TAP_W'(DIV_BASE_SHIFT - 1)];
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            up_q <= CROSS_RST;
            dn_q <= CROSS_RST;
            mir_q <= DACX_MIRROR_BYPASS;
            bg_q <= BANDGAP_RST;
            output_headroom_q <= HEADROOM_RST;
            sel_q <= DACX_SIG_LVDS_P1;
            rdbk_q <= 1'b0;
            lvds_q <= 1'b0;
            sync_q <= 1'b0;
            clr_q <= 1'b0;
            res_q <= 32'h0000_0000;
            ccd_q <= DIV_CODE_RST;
            div_q <= '0;
            cclk_q <= 1'b0;
        end
        else if (clk_en)
        begin
            up_q <= up_d;
            dn_q <= dn_d;
            mir_q <= mir_d;
            bg_q <= bg_d;
            output_headroom_q <= output_headroom_d;
            sel_q <= sel_d;
            rdbk_q <= rdbk_d;
            lvds_q <= lvds_d;
            sync_q <= sync_d;
            clr_q <= clr_d;
            res_q <= res_d;
            ccd_q <= ccd_d;
            div_q <= div_d;
            cclk_q <= cclk_d;
        end
    end

    // ----------------------------------------------------------------
    // Read mux and outputs
    // ----------------------------------------------------------------
    always_comb
    begin
        rd_hit = 1'b1;
        unique case (rd_addr)
            ADDR_CROSS_UP: rd_data = {1'b0, CROSS_FIXED_BITS[0], up_q};
            ADDR_CROSS_DOWN: rd_data = {1'b0, CROSS_FIXED_BITS[0], dn_q};
            ADDR_ANA_MIRROR_BG: rd_data = {mir_q, 3'h0, bg_q};
            ADDR_HEADROOM: rd_data = output_headroom_q;
            ADDR_RESULT_B0: rd_data = res_q[7:0];
            ADDR_RESULT_B1: rd_data = res_q[15:8];
            ADDR_RESULT_B2: rd_data = res_q[23:16];
            ADDR_RESULT_B3: rd_data = res_q[31:24];
            ADDR_CLK_DIV: rd_data = {4'h0, ccd_q};
            default:
            begin
                // Write-only control and unmapped addresses read zero
                rd_data = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    assign trim = '{cross_shift_up: up_q, cross_shift_down: dn_q, mirror_rolloff_select: mir_q,
                    bandgap_temp_trim: bg_q, output_headroom: output_headroom_q};
    assign lvds_selftest_en = lvds_q;
    assign sync_selftest_en = sync_q;
    assign selftest_clear = clr_q;
    assign signature_readback_enable = rdbk_q;
    assign ctrl_clk = cclk_q;
endmodule

// ---- rtl/dacx_pkg.sv ----
// Package: register map, field layout and reset values of the auxiliary control bank
package dacx_pkg;
    // ----------------------------------------------------------------
    // Register addresses
    // ----------------------------------------------------------------
    localparam logic [4:0] ADDR_CROSS_UP = 5'h0a;
    localparam logic [4:0] ADDR_CROSS_DOWN = 5'h0b;
    localparam logic [4:0] ADDR_ANA_MIRROR_BG = 5'h0e;
    localparam logic [4:0] ADDR_HEADROOM = 5'h0f;
    localparam logic [4:0] ADDR_SELF_TEST_CTRL = 5'h11;
    localparam logic [4:0] ADDR_RESULT_B0 = 5'h12;
    localparam logic [4:0] ADDR_RESULT_B1 = 5'h13;
    localparam logic [4:0] ADDR_RESULT_B2 = 5'h14;
    localparam logic [4:0] ADDR_RESULT_B3 = 5'h15;
    localparam logic [4:0] ADDR_CLK_DIV = 5'h16;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CROSS_LSB = 0;
    localparam int CROSS_W = 6;
    localparam int MIRROR_LSB = 6;
    localparam int BANDGAP_LSB = 0;
    localparam int ST_SEL_LSB = 6;
    localparam int ST_READBACK_BIT = 5;
    localparam int ST_LVDS_EN_BIT = 2;
    localparam int ST_SYNC_EN_BIT = 1;
    localparam int ST_CLEAR_BIT = 0;
    localparam int DIV_CODE_LSB = 0;
    localparam int DIV_BASE_SHIFT = 4;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [5:0] CROSS_RST = 6'h00;
    localparam logic [1:0] CROSS_FIXED_BITS = 2'h1;
    localparam logic [1:0] MIRROR_RST = 2'h0;
    localparam logic [2:0] BANDGAP_RST = 3'h0;
    localparam logic [7:0] HEADROOM_RST = 8'hca;
    localparam logic [3:0] DIV_CODE_RST = 4'h0;

    typedef enum logic [1:0] {
        DACX_MIRROR_BYPASS = 2'h0,
        DACX_MIRROR_NARROW = 2'h1,
        DACX_MIRROR_MEDIUM = 2'h2,
        DACX_MIRROR_WIDE = 2'h3
    } dacx_mirror_t;

    typedef enum logic [1:0] {
        DACX_SIG_LVDS_P1 = 2'h0,
        DACX_SIG_LVDS_P2 = 2'h1,
        DACX_SIG_SYNC_P1 = 2'h2,
        DACX_SIG_SYNC_P2 = 2'h3
    } dacx_sig_sel_t;

    // Serial port byte-level access, one byte complete
    typedef struct packed {
        logic wr_stb;
        logic [4:0] addr;
        logic [7:0] wdata;
    } dacx_wr_t;

    // Analog trim settings as seen by the analog macros
    typedef struct packed {
        logic [5:0] cross_shift_up;
        logic [5:0] cross_shift_down;
        dacx_mirror_t mirror_rolloff_select;
        logic [2:0] bandgap_temp_trim;
        logic [7:0] output_headroom;
    } dacx_trim_t;

    // Self-test signatures from the capture and sync checkers
    typedef struct packed {
        logic [31:0] lvds_p1;
        logic [31:0] lvds_p2;
        logic [31:0] sync_p1;
        logic [31:0] sync_p2;
    } dacx_sig_t;
endpackage

// ---- dv/dacx_aux_regs_checker.sv ----
// Concurrent checks for the auxiliary control register bank
`timescale 1ns/1ns
module dacx_aux_regs_checker
    import dacx_pkg::*;
#(
    parameter int DIV_CODE_W = 4
)
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire dacx_pkg::dacx_wr_t wr,
    input wire logic [4:0] rd_addr,
    input wire logic [7:0] rd_data,
    input wire logic rd_hit,
    input wire dacx_pkg::dacx_sig_t sig_in,
    input wire logic sig_valid,
    input wire dacx_pkg::dacx_trim_t trim,
    input wire logic lvds_selftest_en,
    input wire logic sync_selftest_en,
    input wire logic selftest_clear,
    input wire logic signature_readback_enable,
    input wire logic ctrl_clk
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    logic tk;
    logic ctl;
    assign tk = clk_en && wr.wr_stb;
    assign ctl = tk && wr.addr == ADDR_SELF_TEST_CTRL;
    sequence s_clear_req;
        ctl && wr.wdata[ST_CLEAR_BIT];
    endsequence
    sequence s_cleared;
        selftest_clear && !lvds_selftest_en && !sync_selftest_en && !signature_readback_enable;
    endsequence
    chk_up_write:
        assert property (tk && wr.addr == ADDR_CROSS_UP |=> trim.cross_shift_up == $past(wr.wdata[5:0])) else $error("up");
    chk_down_read:
        assert property (rd_addr == ADDR_CROSS_DOWN |-> rd_hit && rd_data == {2'h1, trim.cross_shift_down}) else $error("dn");
    chk_mirror_bg:
        assert property (tk && wr.addr == ADDR_ANA_MIRROR_BG |=> {trim.mirror_rolloff_select, trim.bandgap_temp_trim}
            == {$past(wr.wdata[7:6]), $past(wr.wdata[2:0])}) else $error("mirror");
    chk_headroom_load:
        assert property (tk && wr.addr == ADDR_HEADROOM |=> trim.output_headroom == $past(wr.wdata)) else $error("output_headroom");
    chk_readback_set:
        assert property (ctl && wr.wdata[5] && !wr.wdata[0] |=> signature_readback_enable) else $error("readback");
    chk_lvds_set:
        assert property (ctl && wr.wdata[2] && !wr.wdata[0] |=> lvds_selftest_en) else $error("lvds");
    chk_sync_hold:
        assert property (sync_selftest_en && !ctl |=> sync_selftest_en) else $error("sync");
    chk_clear_all:
        assert property (s_clear_req |=> s_cleared) else $error("clear");
    chk_clear_pulse:
        assert property (selftest_clear && clk_en && !(ctl && wr.wdata[ST_CLEAR_BIT]) |=> !selftest_clear)
            else $error("clear pulse");
    chk_result_hit:
        assert property (rd_addr inside {[ADDR_RESULT_B0:ADDR_RESULT_B3]} |-> rd_hit) else $error("result hit");
    chk_freeze_hold:
        assert property (!clk_en |=> $stable(ctrl_clk) && $stable(trim)) else $error("freeze");
endmodule

bind dacx_aux_regs dacx_aux_regs_checker #(.DIV_CODE_W(DIV_CODE_W)) u_chk (.clk_sys, .arst_n, .clk_en, .wr,
    .rd_addr, .rd_data, .rd_hit, .sig_in, .sig_valid, .trim, .lvds_selftest_en, .sync_selftest_en,
    .selftest_clear, .signature_readback_enable, .ctrl_clk);

// ---- dv/dacx_host_model.sv ----
// Host model issuing byte writes and reads on the register port
`timescale 1ns/1ns
module dacx_host_model
    import dacx_pkg::*;
(
    input wire logic clk_sys,
    output dacx_pkg::dacx_wr_t wr,
    output logic [4:0] rd_addr,
    input wire logic [7:0] rd_data
);
    initial
    begin
        wr = '0;
        rd_addr = 5'h00;
    end
    // Released bus shows inverted values so stale data never passes
    task automatic wr_byte(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        wr <= {1'b1, a, d};
        @(posedge clk_sys);
        wr <= {1'b0, ~a, ~d};
    endtask
    task automatic rd_byte(input logic [4:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        rd_addr <= a;
        @(negedge clk_sys);
        d = rd_data;
    endtask
endmodule

// ---- dv/dacx_aux_regs_test.sv ----
// Self-checking bench for the auxiliary control register bank
`timescale 1ns/1ns
module dacx_aux_regs_test;
    import dacx_pkg::*;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic clk_en = 1'b1;
    logic sig_valid = 1'b0;
    dacx_sig_t sig_in = {32'h1a2b3c4d, 32'h55667788, 32'h99aabbcc, 32'hd0e1f203};
    dacx_wr_t wr;
    dacx_trim_t trim;
    logic [4:0] rd_addr;
    logic [7:0] rd_data;
    logic [7:0] d;
    logic [31:0] exp;
    logic rd_hit, selftest_clear, lvds_selftest_en, sync_selftest_en, signature_readback_enable, ctrl_clk;
    int err_count = 0;
    int checked = 0;
    int n;
    always #5 clk_sys = ~clk_sys;
    dacx_aux_regs u_dacx_aux_regs (.clk_sys, .arst_n, .clk_en, .wr, .rd_addr, .rd_data, .rd_hit, .sig_in,
        .sig_valid, .trim, .lvds_selftest_en, .sync_selftest_en, .selftest_clear, .signature_readback_enable, .ctrl_clk);
    dacx_host_model u_host (.clk_sys, .wr, .rd_addr, .rd_data);
    task automatic check(input logic [31:0] got, input logic [31:0] want);
        checked++;
        if (got !== want)
        begin
            err_count++;
            $display("[ERR] %0t got %h want %h", $time, got, want);
        end
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [31:0] want);
        u_host.rd_byte(a, d);
        check(d, want);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Cycles between two rising edges of the divided clock, bounded
    task automatic rise_gap(output int g);
        logic p;
        g = -1;
        p = 1'b1;
        for (int k = 0; k < 300; k++)
        begin
            @(negedge clk_sys);
            if (ctrl_clk && !p && g >= 0)
            begin
                g++;
                return;
            end
            if (ctrl_clk && !p)
                g = 0;
            else if (g >= 0)
                g++;
            p = ctrl_clk;
        end
        err_count++;
        summarize();
    endtask
    initial
    begin
        repeat (16) @(posedge clk_sys);
        arst_n <= 1'b1;
        rd_chk(ADDR_CROSS_UP, 8'h40);
        rd_chk(ADDR_CROSS_DOWN, 8'h40);
        rd_chk(ADDR_ANA_MIRROR_BG, 8'h00);
        rd_chk(ADDR_HEADROOM, 8'hca);
        rd_chk(5'h1f, 8'h00);
        check(rd_hit, 1'b0);
        $display("reset test done");
        u_host.wr_byte(ADDR_CROSS_UP, 8'hff);
        rd_chk(ADDR_CROSS_UP, 8'h7f);
        u_host.wr_byte(ADDR_CROSS_UP, 8'h00);
        u_host.wr_byte(ADDR_CROSS_DOWN, 8'h2a);
        rd_chk(ADDR_CROSS_DOWN, 8'h6a);
        for (int m = 0; m < 4; m++)
        begin
            u_host.wr_byte(ADDR_ANA_MIRROR_BG, {m[1:0], 6'h3d});
            rd_chk(ADDR_ANA_MIRROR_BG, {m[1:0], 6'h05});
            check(trim.mirror_rolloff_select, m[1:0]);
        end
        u_host.wr_byte(ADDR_HEADROOM, 8'h35);
        rd_chk(ADDR_HEADROOM, 8'h35);
        $display("trim test done");
        @(posedge clk_sys);
        sig_valid <= 1'b1;
        for (int s = 0; s < 4; s++)
        begin
            u_host.wr_byte(ADDR_SELF_TEST_CTRL, {s[1:0], 6'h20});
            exp = sig_in[127 - 32 * s -: 32];
            for (int b = 0; b < 4; b++)
                rd_chk(ADDR_RESULT_B0 + b[4:0], exp[8 * b +: 8]);
        end
        u_host.wr_byte(ADDR_SELF_TEST_CTRL, 8'h06);
        u_host.wr_byte(ADDR_SELF_TEST_CTRL, 8'h00);
        @(posedge clk_sys);
        sig_valid <= 1'b0;
        sig_in <= ~sig_in;
        @(negedge clk_sys);
        check({signature_readback_enable, lvds_selftest_en, sync_selftest_en}, 3'h7);
        rd_chk(ADDR_RESULT_B3, 8'h1a);
        u_host.wr_byte(ADDR_SELF_TEST_CTRL, 8'h01);
        @(negedge clk_sys);
        check({selftest_clear, lvds_selftest_en, sync_selftest_en}, 3'h4);
        rd_chk(ADDR_RESULT_B2, 8'h00);
        check(selftest_clear, 1'b0);
        u_host.wr_byte(ADDR_RESULT_B2, 8'hff);
        rd_chk(ADDR_RESULT_B2, 8'h00);
        $display("self-test test done");
        for (int c = 0; c < 3; c++)
        begin
            u_host.wr_byte(ADDR_CLK_DIV, {4'h0, c[3:0]});
            rise_gap(n);
            rise_gap(n);
            check(n, 1 << (c + DIV_BASE_SHIFT));
        end
        rd_chk(ADDR_CLK_DIV, 8'h02);
        $display("divider test done");
        // Enable low: a write is ignored and the divided clock stops
        @(posedge clk_sys);
        clk_en <= 1'b0;
        u_host.wr_byte(ADDR_HEADROOM, 8'h11);
        @(negedge clk_sys);
        n = ctrl_clk;
        repeat (40) @(negedge clk_sys);
        check(ctrl_clk, n);
        rd_chk(ADDR_HEADROOM, 8'h35);
        @(posedge clk_sys);
        clk_en <= 1'b1;
        u_host.wr_byte(ADDR_CLK_DIV, 8'hff);
        rd_chk(ADDR_CLK_DIV, 8'h0f);
        $display("freeze test done");
        // Reset in mid-run brings back the reset values
        @(posedge clk_sys);
        arst_n <= 1'b0;
        @(posedge clk_sys);
        arst_n <= 1'b1;
        @(negedge clk_sys);
        check({ctrl_clk, signature_readback_enable, trim.output_headroom}, 10'h0ca);
        rd_chk(ADDR_CROSS_DOWN, 8'h40);
        rd_chk(ADDR_CLK_DIV, 8'h00);
        $display("mid-run reset test done");
        summarize();
    end
endmodule
